/* File: pwr_wake_pkg.sv */
// Constants for the power-button and wake-up control block
package pwr_wake_pkg;
    // ------------------------------------------------------------
    // Register indices and byte addresses (byte = 4 * index)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_ACT = 8'h30;
    localparam logic [7:0] IDX_IRQ = 8'h70;
    localparam logic [7:0] IDX_CTRL = 8'he0;
    localparam logic [7:0] IDX_KIDX = 8'he1;
    localparam logic [7:0] IDX_KDAT = 8'he2;
    localparam logic [7:0] IDX_EVT = 8'he3;
    localparam logic [7:0] IDX_IST = 8'hf0;
    localparam logic [7:0] IDX_IMSK = 8'hf1;
    localparam logic [7:0] IDX_MSM = 8'hf2;
    localparam logic [11:0] A_ACT = {2'h0, IDX_ACT, 2'h0};
    localparam logic [11:0] A_IRQ = {2'h0, IDX_IRQ, 2'h0};
    localparam logic [11:0] A_CTRL = {2'h0, IDX_CTRL, 2'h0};
    localparam logic [11:0] A_KIDX = {2'h0, IDX_KIDX, 2'h0};
    localparam logic [11:0] A_KDAT = {2'h0, IDX_KDAT, 2'h0};
    localparam logic [11:0] A_EVT = {2'h0, IDX_EVT, 2'h0};
    localparam logic [11:0] A_IST = {2'h0, IDX_IST, 2'h0};
    localparam logic [11:0] A_IMSK = {2'h0, IDX_IMSK, 2'h0};
    localparam logic [11:0] A_MSM = {2'h0, IDX_MSM, 2'h0};
    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int B_BLOCK = 7;
    localparam int B_KBEN = 6;
    localparam int B_MSEN = 5;
    localparam int B_MSR = 4;
    localparam int B_SWAP = 2;
    localparam int B_MSX = 1;
    localparam int B_KBANY = 0;
    localparam int EV_KB = 0;
    localparam int EV_MS = 1;
    localparam int EV_PS = 2;
    localparam logic [7:0] CTRL_RST = 8'h01;
    localparam logic [7:0] CTRL_WMASK = 8'hf7;
    localparam logic [7:0] KEY_RST = 8'hff;
    // ------------------------------------------------------------
    // Key storage layout and timing
    // ------------------------------------------------------------
    localparam logic [7:0] SET0 = 8'h00;
    localparam logic [7:0] SET1 = 8'h30;
    localparam logic [7:0] SET2 = 8'h40;
    localparam logic [7:0] HIST_LO = 8'h10;
    localparam logic [7:0] HIST_HI = 8'h1e;
    localparam int SET_LEN = 15;
    localparam int CLK_NS = 40;
    localparam int WAKE_PULSE_NS = 640;
    localparam logic [4:0] WAKE_CYC = 5'((WAKE_PULSE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;
endpackage : pwr_wake_pkg

/* File: pwr_wake.sv */
// Power-button gating, keyboard/mouse wake-up and AXI4-Lite registers
// Functional notes
// - Activation bit 0 turns the power-management device on; resets zero.
// - Low four bits pick the interrupt line for the power-event output.
// - Panel switch drives the supply-on output unless the block bit is set.
// - Control bit 6 enables keyboard wake-up through the supply-on output.
// - Control bit 5 enables mouse wake-up through the supply-on output.
// - Bits 1 and 4 choose single or double, left or right click wake.
// - Control bit 2 swaps keyboard and mouse ports; bit 3 reserved.
// - Any-key bit picks any character or only the stored sequence.
// - Wake control resets to 0x01.
// - Eight-bit index selects the stored key character; resets zero.
// - Three key sets live at 0x00-0x0E, 0x30-0x3E, 0x40-0x4E.
// - Latest received keys are recorded and readable at 0x10-0x1E.
// - Data window reads the character at the index; writes skip 0x10-0x1E.
// - Keyboard wake status stays set until the status register is read.
`timescale 1ns/1ps
`default_nettype none
module pwr_wake (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [11:0] s_awaddr_i,
    input wire logic s_awvalid_i,
    output logic s_awready_o,
    input wire logic [31:0] s_wdata_i,
    input wire logic [3:0] s_wstrb_i,
    input wire logic s_wvalid_i,
    output logic s_wready_o,
    output logic [1:0] s_bresp_o,
    output logic s_bvalid_o,
    input wire logic s_bready_i,
    input wire logic [11:0] s_araddr_i,
    input wire logic s_arvalid_i,
    output logic s_arready_o,
    output logic [31:0] s_rdata_o,
    output logic [1:0] s_rresp_o,
    output logic s_rvalid_o,
    input wire logic s_rready_i,
    input wire logic [7:0] port_a_data_i,
    input wire logic port_a_valid_i,
    input wire logic [7:0] port_b_data_i,
    input wire logic port_b_valid_i,
    input wire logic panel_switch_in_i,
    output logic power_supply_on_out_n_o,
    output logic power_event_out_o,
    output logic [3:0] power_event_irq_o,
    output logic irq_o
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic act;
        logic [3:0] irq_sel;
        logic [7:0] ctrl;
        logic [7:0] kidx;
        logic [255:0][7:0] mem;
        logic [2:0] evt;
        logic [2:0] ist;
        logic [2:0] imsk;
        logic msm;
        logic aw_h;
        logic [11:0] awaddr;
        logic w_h;
        logic [7:0] wdata;
        logic wstb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [1:0] ms_cnt;
        logic [1:0] ms_btn;
        logic ms_one;
        logic [4:0] pulse;
        logic ps_n;
    } state_s;

    state_s r;
    state_s n;
    logic wr_go;
    logic kb_v;
    logic [7:0] kb_d;
    logic ms_v;
    logic [7:0] ms_d;
    logic kb_evt;
    logic ms_evt;
    logic ps_evt;
    logic [1:0] press;
    logic sel_hit;
    logic mapped;
    logic [7:0] rd_val;

    // Ends-with match of one stored set against the key history.
    // A 0x00 entry ends the set early; an empty set never matches.
    function automatic logic seq_hit(input logic [255:0][7:0] m, input logic [7:0] base);
        logic ok;
        int len;
        ok = 1'b1;
        len = pwr_wake_pkg::SET_LEN;
        for (int i = pwr_wake_pkg::SET_LEN - 1; i >= 0; i--)
        begin
            if (m[8'(base + i)] == 8'h00)
                len = i;
        end
        for (int j = 0; j < pwr_wake_pkg::SET_LEN; j++)
        begin
            if (j < len && m[8'(pwr_wake_pkg::HIST_HI - j)] != m[8'(base + len - 1 - j)])
                ok = 1'b0;
        end
        return ok && (len != 0);
    endfunction : seq_hit

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Bus handshakes come straight from the hold flags
    assign s_awready_o = !r.aw_h;
    assign s_wready_o = !r.w_h;
    assign s_bvalid_o = r.bvalid;
    assign s_bresp_o = r.bresp;
    assign s_arready_o = !r.rvalid;
    assign s_rvalid_o = r.rvalid;
    assign s_rdata_o = r.rdata;
    assign s_rresp_o = r.rresp;
    assign power_supply_on_out_n_o = r.ps_n;
    assign irq_o = |(r.ist & r.imsk);
    assign power_event_irq_o = r.irq_sel;
    assign power_event_out_o = r.act & irq_o;

    // ------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------
    always_comb
    begin
        mapped = 1'b1;
        rd_val = 8'h00;
        case (s_araddr_i)
            pwr_wake_pkg::A_ACT: rd_val = {7'h00, r.act};
            pwr_wake_pkg::A_IRQ: rd_val = {4'h0, r.irq_sel};
            pwr_wake_pkg::A_CTRL: rd_val = r.ctrl;
            pwr_wake_pkg::A_KIDX: rd_val = r.kidx;
            pwr_wake_pkg::A_KDAT: rd_val = r.mem[r.kidx];
            pwr_wake_pkg::A_EVT: rd_val = {5'h00, r.evt};
            pwr_wake_pkg::A_IST: rd_val = {5'h00, r.ist};
            pwr_wake_pkg::A_IMSK: rd_val = {5'h00, r.imsk};
            pwr_wake_pkg::A_MSM: rd_val = {7'h00, r.msm};
            default: mapped = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        n = r;
        wr_go = r.aw_h && r.w_h && !r.bvalid;
        kb_v = r.ctrl[pwr_wake_pkg::B_SWAP] ? port_b_valid_i : port_a_valid_i;
        kb_d = r.ctrl[pwr_wake_pkg::B_SWAP] ? port_b_data_i : port_a_data_i;
        ms_v = r.ctrl[pwr_wake_pkg::B_SWAP] ? port_a_valid_i : port_b_valid_i;
        ms_d = r.ctrl[pwr_wake_pkg::B_SWAP] ? port_a_data_i : port_b_data_i;
        press = 2'b00;
        sel_hit = 1'b0;
        ms_evt = 1'b0;
        kb_evt = 1'b0;
        ps_evt = panel_switch_in_i && !r.ctrl[pwr_wake_pkg::B_BLOCK];

        // Write channel capture, either order
        if (s_awvalid_i && !r.aw_h)
        begin
            n.aw_h = 1'b1;
            n.awaddr = s_awaddr_i;
        end
        if (s_wvalid_i && !r.w_h)
        begin
            n.w_h = 1'b1;
            n.wdata = s_wdata_i[7:0];
            n.wstb = s_wstrb_i[0];
        end
        if (r.bvalid && s_bready_i)
            n.bvalid = 1'b0;

        // Register write; lane 0 carries the 8-bit value
        if (wr_go)
        begin
            n.aw_h = 1'b0;
            n.w_h = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = pwr_wake_pkg::RESP_OK;
            case (r.awaddr)
                pwr_wake_pkg::A_ACT: if (r.wstb) n.act = r.wdata[0];
                pwr_wake_pkg::A_IRQ: if (r.wstb) n.irq_sel = r.wdata[3:0];
                pwr_wake_pkg::A_CTRL: if (r.wstb) n.ctrl = r.wdata & pwr_wake_pkg::CTRL_WMASK;
                pwr_wake_pkg::A_KIDX: if (r.wstb) n.kidx = r.wdata;
                pwr_wake_pkg::A_KDAT:
                begin
                    if (r.wstb && !(r.kidx >= pwr_wake_pkg::HIST_LO &&
                                    r.kidx <= pwr_wake_pkg::HIST_HI))
                        n.mem[r.kidx] = r.wdata;
                end
                pwr_wake_pkg::A_EVT: ;
                pwr_wake_pkg::A_IST: if (r.wstb) n.ist = r.ist & ~r.wdata[2:0];
                pwr_wake_pkg::A_IMSK: if (r.wstb) n.imsk = r.wdata[2:0];
                pwr_wake_pkg::A_MSM: if (r.wstb) n.msm = r.wdata[0];
                default: n.bresp = pwr_wake_pkg::RESP_ERR;
            endcase
        end

        // Read channel; data registered one cycle after the address
        if (r.rvalid && s_rready_i)
            n.rvalid = 1'b0;
        if (s_arvalid_i && !r.rvalid)
        begin
            n.rvalid = 1'b1;
            n.rdata = {24'h000000, rd_val};
            n.rresp = mapped ? pwr_wake_pkg::RESP_OK : pwr_wake_pkg::RESP_ERR;
            if (s_araddr_i == pwr_wake_pkg::A_EVT)
                n.evt = 3'b000;
        end

        // shift keyboard bytes into the history window
        if (kb_v)
        begin
            for (int i = 0; i < pwr_wake_pkg::SET_LEN - 1; i++)
                n.mem[8'(pwr_wake_pkg::HIST_LO + i)] = r.mem[8'(pwr_wake_pkg::HIST_LO + i + 1)];
            n.mem[pwr_wake_pkg::HIST_HI] = kb_d;
            if (r.ctrl[pwr_wake_pkg::B_KBANY])
                kb_evt = 1'b1;
            else
                kb_evt = seq_hit(n.mem, pwr_wake_pkg::SET0) ||
                         seq_hit(n.mem, pwr_wake_pkg::SET1) ||
                         seq_hit(n.mem, pwr_wake_pkg::SET2);
        end
        kb_evt = kb_evt && r.ctrl[pwr_wake_pkg::B_KBEN];

        // Mouse packets are three bytes; buttons sit in the first
        if (ms_v)
        begin
            n.ms_cnt = (r.ms_cnt == 2'd2) ? 2'd0 : r.ms_cnt + 2'd1;
            if (r.ms_cnt == 2'd0)
            begin
                press = ms_d[1:0] & ~r.ms_btn;
                n.ms_btn = ms_d[1:0];
            end
        end
        // wake event selection; double click has no time window
        sel_hit = r.ctrl[pwr_wake_pkg::B_MSR] ? press[1] : press[0];
        if (r.msm)
            ms_evt = r.ctrl[pwr_wake_pkg::B_MSX] ? ms_v : |press;
        else if (r.ctrl[pwr_wake_pkg::B_MSX])
            ms_evt = sel_hit;
        else
        begin
            ms_evt = sel_hit && r.ms_one;
            if (sel_hit)
                n.ms_one = !r.ms_one;
        end
        ms_evt = ms_evt && r.ctrl[pwr_wake_pkg::B_MSEN];

        // Sticky status; a new event beats a same-cycle clear
        n.evt = n.evt | {ps_evt, ms_evt, kb_evt};
        n.ist = n.ist | {ps_evt, ms_evt, kb_evt};

        // wake pulse on the supply-on output
        if (kb_evt || ms_evt)
            n.pulse = pwr_wake_pkg::WAKE_CYC;
        else if (r.pulse != 5'h00)
            n.pulse = r.pulse - 5'h01;
        n.ps_n = !(ps_evt || n.pulse != 5'h00);

        if (rst_i)
        begin
            n = '0;
            n.ctrl = pwr_wake_pkg::CTRL_RST;
            n.mem = {256{pwr_wake_pkg::KEY_RST}};
            n.ps_n = 1'b1;
        end
    end

    // Single register stage for all state
    always_ff @(posedge clk_i)
        r <= n;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    chk_ctrl_reset: assert property ($past(rst_i) |-> r.ctrl == 8'h01)
        else $error("wake control reset value wrong");
    chk_pme_active: assert property (power_event_out_o |-> r.act)
        else $error("power event while inactive");
    chk_irq_select: assert property (wr_go && r.awaddr == pwr_wake_pkg::A_IRQ && r.wstb
        |=> power_event_irq_o == $past(r.wdata[3:0]))
        else $error("irq select not taken");
    chk_panel_pass: assert property (panel_switch_in_i && !r.ctrl[7]
        |=> !power_supply_on_out_n_o)
        else $error("panel switch not passed");
    chk_kb_enable: assert property ($rose(r.evt[0]) |-> $past(r.ctrl[6]))
        else $error("keyboard wake while disabled");
    chk_ms_enable: assert property ($rose(r.ist[1]) |-> $past(r.ctrl[5]))
        else $error("mouse wake while disabled");
    chk_index_write: assert property (wr_go && r.awaddr == pwr_wake_pkg::A_KIDX && r.wstb
        |=> r.kidx == $past(r.wdata))
        else $error("index write lost");
    chk_hist_record: assert property (kb_v |=> r.mem[8'h1e] == $past(kb_d))
        else $error("key not recorded");
    chk_evt_readclr: assert property (s_arvalid_i && !r.rvalid
        && s_araddr_i == pwr_wake_pkg::A_EVT && !kb_evt |=> !r.evt[0])
        else $error("status not cleared by read");
    chk_wake_pulse: assert property (kb_evt || ms_evt
        |=> !power_supply_on_out_n_o [*8])
        else $error("wake pulse too short");
endmodule : pwr_wake
`default_nettype wire

/* File: wake_partner.sv */
// Behavioural keyboard, mouse and front panel switch for the wake block
`timescale 1ns/1ps
`default_nettype none
module wake_partner (
    input wire logic clk_i,
    output logic [7:0] a_data_o,
    output logic a_valid_o,
    output logic [7:0] b_data_o,
    output logic b_valid_o,
    output logic panel_o
);
    // Quiet lines start at known levels
    initial
    begin
        a_data_o = 8'h00;
        a_valid_o = 1'b0;
        b_data_o = 8'h00;
        b_valid_o = 1'b0;
        panel_o = 1'b0;
    end
    // ------------------------------------------------------------
    // Byte strobes
    // ------------------------------------------------------------
    // One byte per one-cycle strobe; idle data flips so stale bytes never look valid
    task automatic send(input logic on_b, input logic [7:0] b);
        @(posedge clk_i);
        if (on_b)
        begin
            b_data_o <= b;
            b_valid_o <= 1'b1;
        end
        else
        begin
            a_data_o <= b;
            a_valid_o <= 1'b1;
        end
        @(posedge clk_i);
        a_valid_o <= 1'b0;
        b_valid_o <= 1'b0;
        a_data_o <= ~a_data_o;
        b_data_o <= ~b_data_o;
    endtask : send
    // Three-byte mouse packet, buttons in the first byte
    task automatic pkt(input logic [1:0] btn);
        send(1'b1, {6'h02, btn});
        send(1'b1, 8'h00);
        send(1'b1, 8'h00);
    endtask : pkt
    // Panel switch level
    task automatic set_panel(input logic v);
        @(posedge clk_i);
        panel_o <= v;
    endtask : set_panel
endmodule : wake_partner
`default_nettype wire

/* File: test_power_button_wakeup_control.sv */
// Self-checking bench for the power-button and wake-up block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin errors++; \
    $display("FAIL %s expected %h seen %h", nm, e, g); end end
module test_power_button_wakeup_control;
    logic clk_i, rst_i, awvalid, wvalid, bready, arvalid, rready;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [7:0] a_d, b_d;
    logic a_v, b_v, panel;
    logic awready, wready, bvalid, arready, rvalid, sup_n, pev, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [3:0] irq_sel;
    logic [7:0] mctl [5] = '{8'h22, 8'h32, 8'h20, 8'h30, 8'h02};
    logic [1:0] mbtn [5] = '{2'b01, 2'b10, 2'b01, 2'b10, 2'b01};
    logic [7:0] bases [3] = '{pwr_wake_pkg::SET0, pwr_wake_pkg::SET1, pwr_wake_pkg::SET2};
    int errors = 0;
    int tests_run = 0;
    pwr_wake dut_u (.clk_i(clk_i), .rst_i(rst_i), .s_awaddr_i(awaddr), .s_awvalid_i(awvalid),
        .s_awready_o(awready), .s_wdata_i(wdata), .s_wstrb_i(wstrb), .s_wvalid_i(wvalid),
        .s_wready_o(wready), .s_bresp_o(bresp), .s_bvalid_o(bvalid), .s_bready_i(bready),
        .s_araddr_i(araddr), .s_arvalid_i(arvalid), .s_arready_o(arready), .s_rdata_o(rdata),
        .s_rresp_o(rresp), .s_rvalid_o(rvalid), .s_rready_i(rready), .port_a_data_i(a_d),
        .port_a_valid_i(a_v), .port_b_data_i(b_d), .port_b_valid_i(b_v),
        .panel_switch_in_i(panel), .power_supply_on_out_n_o(sup_n), .power_event_out_o(pev),
        .power_event_irq_o(irq_sel), .irq_o(irq));
    wake_partner partner_u (.clk_i(clk_i), .a_data_o(a_d), .a_valid_o(a_v), .b_data_o(b_d),
        .b_valid_o(b_v), .panel_o(panel));
    // 25 MHz clock
    initial
    begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    // ------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------
    // Address and data offered together; each dropped once its ready is seen
    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s,
        output logic [1:0] r);
        int n;
        @(posedge clk_i);
        n = 0;
        awaddr <= a;
        wdata <= {24'h0, d};
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge clk_i);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end
        while (!bvalid && n < 50);
        r = bresp;
        bready <= 1'b0;
        if (n >= 50) errors++;
    endtask : wr
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge clk_i);
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge clk_i);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end
        while (!rvalid && n < 50);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        if (n >= 50) errors++;
    endtask : rd
    task automatic wr2(input logic [11:0] a, input logic [7:0] d);
        logic [1:0] r;
        wr(a, d, 4'h1, r);
    endtask : wr2
    task automatic rchk(input logic [11:0] a, input logic [7:0] e);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        `CHK($sformatf("reg %h", a), {24'h0, e}, d)
    endtask : rchk
    // Event status clears on read, so each call also consumes the flags
    task automatic evt(input logic [7:0] e);
        rchk(pwr_wake_pkg::A_EVT, e);
    endtask : evt
    task automatic do_reset();
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask : do_reset
    // Cycles the supply-on request stays low, counted from the strobe edge
    task automatic low_len(output int n);
        #1;
        n = 0;
        while (sup_n === 1'b0 && n < 100)
        begin
            n++;
            @(posedge clk_i);
            #1;
        end
    endtask : low_len
    task automatic give_verdict();
        $display("Comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : give_verdict
    // Watchdog sized well above the few hundred cycles the sequence needs
    initial
    begin
        repeat (20000) @(posedge clk_i);
        errors++;
        give_verdict();
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        logic [31:0] d;
        logic [1:0] r;
        int n;
        rst_i = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wdata, wstrb} = {12'h0, 12'h0, 32'h0, 4'h1};
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        rchk(pwr_wake_pkg::A_ACT, 8'h00);
        rchk(pwr_wake_pkg::A_IRQ, 8'h00);
        rchk(pwr_wake_pkg::A_CTRL, 8'h01);
        rchk(pwr_wake_pkg::A_KIDX, 8'h00);
        // Lane 0 strobe low: the write is answered but leaves the index alone
        wr(pwr_wake_pkg::A_KIDX, 8'h55, 4'h0, r);
        `CHK("strobeless wresp", pwr_wake_pkg::RESP_OK, r)
        rchk(pwr_wake_pkg::A_KIDX, 8'h00);
        for (int i = 0; i < 16; i++)
        begin
            wr2(pwr_wake_pkg::A_IRQ, 8'(i));
            `CHK("irq select", 4'(i), irq_sel)
        end
        wr2(pwr_wake_pkg::A_CTRL, 8'hff);
        rchk(pwr_wake_pkg::A_CTRL, 8'hf7);
        rd(12'h004, d, r);
        `CHK("unmapped resp", pwr_wake_pkg::RESP_ERR, r)
        `CHK("unmapped data", 32'h0, d)
        wr(12'h004, 8'h00, 4'h1, r);
        `CHK("unmapped wresp", pwr_wake_pkg::RESP_ERR, r)
        // Panel switch passes through only while not blocked
        wr2(pwr_wake_pkg::A_CTRL, 8'h00);
        partner_u.set_panel(1'b1);
        repeat (2) @(posedge clk_i);
        #1 `CHK("supply on", 1'b0, sup_n)
        partner_u.set_panel(1'b0);
        repeat (20) @(posedge clk_i);
        wr2(pwr_wake_pkg::A_CTRL, 8'h80);
        partner_u.set_panel(1'b1);
        repeat (2) @(posedge clk_i);
        #1 `CHK("supply blocked", 1'b1, sup_n)
        partner_u.set_panel(1'b0);
        rd(pwr_wake_pkg::A_EVT, d, r);
        // Any key wakes when enabled; the pulse length is fixed
        wr2(pwr_wake_pkg::A_CTRL, 8'h41);
        partner_u.send(1'b0, 8'h1c);
        low_len(n);
        `CHK("wake pulse", 16, n)
        evt(8'h01);
        evt(8'h00);
        wr2(pwr_wake_pkg::A_CTRL, 8'h01);
        partner_u.send(1'b0, 8'h1c);
        #1 `CHK("kb disabled", 1'b1, sup_n)
        evt(8'h00);
        // Each stored set wakes only on its keys in order
        for (int s = 0; s < 3; s++)
        begin
            for (int k = 0; k < 3; k++)
            begin
                wr2(pwr_wake_pkg::A_KIDX, bases[s] + 8'(k));
                wr2(pwr_wake_pkg::A_KDAT, (k == 2) ? 8'h00 : bases[s] + 8'(k) + 8'h21);
            end
            wr2(pwr_wake_pkg::A_KIDX, bases[s] + 8'h01);
            rchk(pwr_wake_pkg::A_KDAT, bases[s] + 8'h22);
            wr2(pwr_wake_pkg::A_CTRL, 8'h40);
            partner_u.send(1'b0, bases[s] + 8'h22);
            partner_u.send(1'b0, bases[s] + 8'h21);
            evt(8'h00);
            partner_u.send(1'b0, bases[s] + 8'h22);
            evt(8'h01);
            wr2(pwr_wake_pkg::A_KIDX, pwr_wake_pkg::HIST_HI - 8'h01);
            rchk(pwr_wake_pkg::A_KDAT, bases[s] + 8'h21);
        end
        // Swapped ports: keyboard bytes arrive on the second port
        wr2(pwr_wake_pkg::A_CTRL, 8'h45);
        partner_u.send(1'b1, 8'h1c);
        evt(8'h01);
        partner_u.send(1'b0, 8'h1c);
        evt(8'h00);
        // Mouse click modes, restarted from reset so click counts start clean
        for (int i = 0; i < 5; i++)
        begin
            do_reset();
            wr2(pwr_wake_pkg::A_CTRL, mctl[i]);
            partner_u.pkt(~mbtn[i]);
            partner_u.pkt(2'b00);
            partner_u.pkt(mbtn[i]);
            if (!mctl[i][1])
            begin
                evt(8'h00);
                partner_u.pkt(2'b00);
                partner_u.pkt(mbtn[i]);
            end
            evt({6'h0, mctl[i][5], 1'b0});
        end
        // Any-activity select: a press of either button, then any mouse byte
        do_reset();
        wr2(pwr_wake_pkg::A_MSM, 8'h01);
        rchk(pwr_wake_pkg::A_MSM, 8'h01);
        wr2(pwr_wake_pkg::A_CTRL, 8'h20);
        partner_u.pkt(2'b10);
        evt(8'h02);
        wr2(pwr_wake_pkg::A_CTRL, 8'h22);
        partner_u.send(1'b1, 8'h00);
        evt(8'h02);
        // Interrupt: masked, unmasked, gated by activation, cleared
        do_reset();
        wr2(pwr_wake_pkg::A_CTRL, 8'h41);
        wr2(pwr_wake_pkg::A_ACT, 8'h01);
        partner_u.send(1'b0, 8'h1c);
        #1 `CHK("irq masked", 1'b0, irq)
        rchk(pwr_wake_pkg::A_IST, 8'h01);
        wr2(pwr_wake_pkg::A_IMSK, 8'h01);
        #1 `CHK("irq", 1'b1, irq)
        `CHK("power event", 1'b1, pev)
        wr2(pwr_wake_pkg::A_ACT, 8'h00);
        #1 `CHK("power event off", 1'b0, pev)
        wr2(pwr_wake_pkg::A_IST, 8'h01);
        #1 `CHK("irq cleared", 1'b0, irq)
        give_verdict();
    end
endmodule : test_power_button_wakeup_control
`default_nettype wire
